// ==== rtl/scp_defines.vh ====
// scp_defines.vh - constants for the synthesizer serial configuration port
// assumes inclusion by bare name from rtl files; definitions only
`ifndef SCP_DEFINES_VH
`define SCP_DEFINES_VH

// serial word layout
`define SCP_WORD_W        22
`define SCP_ADDR_W        4
`define SCP_DATA_W        18
`define SCP_ADDR_MSB      21
`define SCP_ADDR_LSB      18

// internal register indices reached over the serial port
`define SCP_IDX_GAIN      4'h1
`define SCP_IDX_PWR       4'h2
`define SCP_IDX_N_RF1     4'h3
`define SCP_IDX_N_RF2     4'h4
`define SCP_IDX_N_IF      4'h5
`define SCP_IDX_R_RF1     4'h6
`define SCP_IDX_R_RF2     4'h7
`define SCP_IDX_R_IF      4'h8
`define SCP_IDX_AUX       4'h9
`define SCP_NUM_REGS      16

// power register fields
`define SCP_PWR_IF_BIT    0
`define SCP_PWR_RF_BIT    1
// if output divider select in aux register
`define SCP_IFDIV_LSB     10
`define SCP_IFDIV_MSB     11

// self-tune timing: 13 update periods at a nominal 200 kHz update rate
`define SCP_TUNE_NS       65000
`define SCP_CLK_NS        4

// apb register map (byte addresses)
`define SCP_APB_CTRL      8'h00
`define SCP_APB_STATUS    8'h04
`define SCP_APB_LASTWORD  8'h08
`define SCP_APB_REGRD     8'h0C
`define SCP_CTRL_RST      32'h00000000

`endif

// ==== rtl/scp_sync2.v ====
// scp_sync2.v - two flip-flop synchroniser for one asynchronous level
// assumes the destination clock is sys_clk_in; first stage read only by second
`timescale 1ns/1ps
`default_nettype none

module scp_sync2
(
  input  wire sys_clk_in,
  input  wire arst_n_in,
  input  wire async_in,
  output reg  sync_out
);

  reg meta_reg;

  // reset value high: matches idle level of active-low pins
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      meta_reg <= 1'b1;
      sync_out <= 1'b1;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // scp_sync2

`default_nettype wire

// ==== rtl/scp_config_port.v ====
// scp_config_port.v - three-wire serial configuration port of the synthesizer
// assumes serial pins are asynchronous to sys_clk_in (250 MHz) and are
// sampled here; software reaches the status and control over APB
`timescale 1ns/1ps
`default_nettype none
`include "scp_defines.vh"

module scp_config_port
(
  input  wire        sys_clk_in,
  input  wire        arst_n_in,
  // serial pins
  input  wire        serial_clk_in,
  input  wire        serial_enable_n_in,
  input  wire        serial_data_line_in,
  input  wire        power_down_n_pin_in,
  // apb slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [7:0]  paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  // synthesizer controls
  output reg         rf_loop_sel_out,
  output reg         rf_loop_powered_out,
  output reg         if_loop_powered_out,
  output reg         rf_tune_busy_out,
  output reg         if_tune_busy_out,
  output reg  [1:0]  if_div_sel_out,
  output reg  [3:0]  if_div_ratio_out
);

  localparam integer TUNE_CYC_I = (`SCP_TUNE_NS + `SCP_CLK_NS - 1) / `SCP_CLK_NS;
  localparam [15:0]  TUNE_CYC   = TUNE_CYC_I[15:0];

  // synchronised pins
  wire sclk_s;
  wire serial_enable_n_s;
  wire sdat_s;
  wire pwdn_s;

  scp_sync2 u_sync_clk
  (
    .sys_clk_in (sys_clk_in),
    .arst_n_in  (arst_n_in),
    .async_in   (serial_clk_in),
    .sync_out   (sclk_s)
  );
  scp_sync2 u_sync_en
  (
    .sys_clk_in (sys_clk_in),
    .arst_n_in  (arst_n_in),
    .async_in   (serial_enable_n_in),
    .sync_out   (serial_enable_n_s)
  );
  scp_sync2 u_sync_dat
  (
    .sys_clk_in (sys_clk_in),
    .arst_n_in  (arst_n_in),
    .async_in   (serial_data_line_in),
    .sync_out   (sdat_s)
  );
  scp_sync2 u_sync_pd
  (
    .sys_clk_in (sys_clk_in),
    .arst_n_in  (arst_n_in),
    .async_in   (power_down_n_pin_in),
    .sync_out   (pwdn_s)
  );

  // previous levels for edge detection (read synchronised copies only)
  reg sclk_d_reg;
  reg serial_enable_n_d_reg;
  reg pwdn_d_reg;
  reg pwdn_seen_reg;

  wire sclk_rise = sclk_s & ~sclk_d_reg;
  wire serial_enable_n_rise = serial_enable_n_s & ~serial_enable_n_d_reg;
  wire pwdn_rise = pwdn_s & ~pwdn_d_reg & pwdn_seen_reg;
  wire pwdn_fall = ~pwdn_s & pwdn_d_reg & pwdn_seen_reg;

  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      sclk_d_reg    <= 1'b1; // matches sync reset level: no false rise
      serial_enable_n_d_reg    <= 1'b1;
      pwdn_d_reg    <= 1'b0;
      pwdn_seen_reg <= 1'b0;
    end
    else
    begin
      sclk_d_reg    <= sclk_s;
      serial_enable_n_d_reg    <= serial_enable_n_s;
      pwdn_d_reg    <= pwdn_s;
      // first sample after reset only primes the pin history
      pwdn_seen_reg <= 1'b1;
    end
  end

  // shift register: 22 bits, oldest bits fall off the top
  reg [`SCP_WORD_W-1:0] shift_reg;
  reg [`SCP_WORD_W-1:0] last_word_reg;
  reg [5:0]             bit_cnt_reg;

  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      shift_reg   <= 22'h000000;
      bit_cnt_reg <= 6'h00;
    end
    else if (!serial_enable_n_s && sclk_rise)
    begin
      shift_reg   <= {shift_reg[`SCP_WORD_W-2:0], sdat_s};
      if (bit_cnt_reg != 6'h3F)
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
    end
    else if (serial_enable_n_rise)
      bit_cnt_reg <= 6'h00;
  end

  // field split of the shifted word
  wire [`SCP_ADDR_W-1:0] word_addr = shift_reg[`SCP_ADDR_MSB:`SCP_ADDR_LSB];
  wire [`SCP_DATA_W-1:0] word_data = shift_reg[`SCP_DATA_W-1:0];

  // internal register file, indexed by address
  reg [`SCP_DATA_W-1:0] regs_reg [0:`SCP_NUM_REGS-1];
  integer i;

  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      for (i = 0; i < `SCP_NUM_REGS; i = i + 1)
        regs_reg[i] <= 18'h00000;
      last_word_reg <= 22'h000000;
    end
    else if (serial_enable_n_rise)
    begin
      regs_reg[word_addr] <= word_data;
      last_word_reg       <= shift_reg;
    end
  end

  // commit classification
  wire commit_pwr = serial_enable_n_rise && (word_addr == `SCP_IDX_PWR);
  wire pwr_ones   = word_data[`SCP_PWR_IF_BIT] & word_data[`SCP_PWR_RF_BIT];
  wire pwr_zeros  = ~word_data[`SCP_PWR_IF_BIT] & ~word_data[`SCP_PWR_RF_BIT];
  wire pup_req    = pwdn_rise | (commit_pwr & pwr_ones);
  wire pdn_req    = pwdn_fall | (commit_pwr & pwr_zeros);
  // pin rise and zero commit together: power-up wins in every block
  wire pdn_win    = pdn_req & ~pup_req;
  wire wr_rf1     = serial_enable_n_rise && (word_addr == `SCP_IDX_N_RF1 ||
                                  word_addr == `SCP_IDX_R_RF1);
  wire wr_rf2     = serial_enable_n_rise && (word_addr == `SCP_IDX_N_RF2 ||
                                  word_addr == `SCP_IDX_R_RF2);
  wire wr_if      = serial_enable_n_rise && (word_addr == `SCP_IDX_N_IF ||
                                  word_addr == `SCP_IDX_R_IF);

  // rf loop select and power state
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rf_loop_sel_out     <= 1'b0;
      rf_loop_powered_out <= 1'b0;
      if_loop_powered_out <= 1'b0;
    end
    else
    begin
      // last divider written picks the loop; only one active
      if (wr_rf1)
        rf_loop_sel_out <= 1'b0;
      else if (wr_rf2)
        rf_loop_sel_out <= 1'b1;
      // a request wins over nothing; power-up is tested first, so it wins when a pin edge meets an opposite commit
      if (pup_req)
      begin
        rf_loop_powered_out <= 1'b1;
        if_loop_powered_out <= 1'b1;
      end
      else if (pdn_req)
      begin
        rf_loop_powered_out <= 1'b0;
        if_loop_powered_out <= 1'b0;
      end
    end
  end

  // self-tune triggers: power-up of an off loop, or new frequency on live loop
  wire rf_tune_go = (pup_req & ~rf_loop_powered_out) |
                    ((wr_rf1 | wr_rf2) & rf_loop_powered_out);
  wire if_tune_go = (pup_req & ~if_loop_powered_out) |
                    (wr_if & if_loop_powered_out);

  reg [15:0] rf_tune_cnt_reg;
  reg [15:0] if_tune_cnt_reg;

  // rf tune timer; a fresh trigger restarts the run, power-down aborts it
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rf_tune_cnt_reg  <= 16'h0000;
      rf_tune_busy_out <= 1'b0;
    end
    else if (pdn_win)
    begin
      rf_tune_cnt_reg  <= 16'h0000;
      rf_tune_busy_out <= 1'b0;
    end
    else if (rf_tune_go)
    begin
      rf_tune_cnt_reg  <= TUNE_CYC;
      rf_tune_busy_out <= 1'b1;
    end
    else if (rf_tune_cnt_reg != 16'h0000)
    begin
      rf_tune_cnt_reg  <= rf_tune_cnt_reg - 16'h0001;
      rf_tune_busy_out <= (rf_tune_cnt_reg != 16'h0001);
    end
  end

  // if tune timer; same policy, so a powered loop never sits untuned
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      if_tune_cnt_reg  <= 16'h0000;
      if_tune_busy_out <= 1'b0;
    end
    else if (pdn_win)
    begin
      if_tune_cnt_reg  <= 16'h0000;
      if_tune_busy_out <= 1'b0;
    end
    else if (if_tune_go)
    begin
      if_tune_cnt_reg  <= TUNE_CYC;
      if_tune_busy_out <= 1'b1;
    end
    else if (if_tune_cnt_reg != 16'h0000)
    begin
      if_tune_cnt_reg  <= if_tune_cnt_reg - 16'h0001;
      if_tune_busy_out <= (if_tune_cnt_reg != 16'h0001);
    end
  end

  // if output divider: select code to ratio 1, 2, 4, 8
  wire [1:0] div_code = regs_reg[`SCP_IDX_AUX][`SCP_IFDIV_MSB:`SCP_IFDIV_LSB];

  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      if_div_sel_out   <= 2'h0;
      if_div_ratio_out <= 4'h1;
    end
    else
    begin
      if_div_sel_out <= div_code;
      case (div_code)
        2'h0:    if_div_ratio_out <= 4'h1;
        2'h1:    if_div_ratio_out <= 4'h2;
        2'h2:    if_div_ratio_out <= 4'h4;
        default: if_div_ratio_out <= 4'h8;
      endcase
    end
  end

  // apb: ctrl holds a register-readback index; status shows port state
  reg  [3:0]  rd_idx_reg;
  reg  [31:0] rd_mux;
  wire        apb_setup  = psel_in & ~penable_in;
  wire        apb_access = psel_in & penable_in & pready_out;

  always @*
  begin
    rd_mux = 32'h00000000;
    case (paddr_in)
      `SCP_APB_CTRL:     rd_mux = {28'h0000000, rd_idx_reg};
      `SCP_APB_STATUS:   rd_mux = {20'h00000, bit_cnt_reg, if_tune_busy_out,
                                   rf_tune_busy_out, if_loop_powered_out,
                                   rf_loop_powered_out, rf_loop_sel_out, serial_enable_n_s};
      `SCP_APB_LASTWORD: rd_mux = {10'h000, last_word_reg};
      `SCP_APB_REGRD:    rd_mux = {14'h0000, regs_reg[rd_idx_reg]};
      default:           rd_mux = 32'h00000000;
    endcase
  end

  wire addr_ok = (paddr_in == `SCP_APB_CTRL) || (paddr_in == `SCP_APB_STATUS) ||
                 (paddr_in == `SCP_APB_LASTWORD) || (paddr_in == `SCP_APB_REGRD);

  // one wait-free access phase: pready rises in the cycle after setup
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
    else
    begin
      pready_out  <= apb_setup;
      pslverr_out <= apb_setup & ~addr_ok;
    end
  end

  // read data captured at setup, cleared once the access completes
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      prdata_out <= 32'h00000000;
    else if (apb_setup && !pwrite_in)
      prdata_out <= rd_mux;
    else if (apb_access)
      prdata_out <= 32'h00000000;
  end

  // readback index changes only in a completed access, never at setup
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rd_idx_reg <= 4'h0;
    else if (apb_access && pwrite_in && paddr_in == `SCP_APB_CTRL)
      rd_idx_reg <= pwdata_in[3:0];
  end

endmodule // scp_config_port

`default_nettype wire

// ==== tb/scp_config_port_props.sv ====
// props: port assertions for the serial configuration port
// assumes a bind onto scp_config_port; sees its ports only
`timescale 1ns/1ps
`default_nettype none
module scp_config_port_props
(
  input wire       sys_clk_in,
  input wire       arst_n_in,
  input wire       serial_enable_n_in,
  input wire       power_down_n_pin_in,
  input wire       rf_loop_sel_out,
  input wire       rf_loop_powered_out,
  input wire       if_loop_powered_out,
  input wire       rf_tune_busy_out,
  input wire       if_tune_busy_out,
  input wire [1:0] if_div_sel_out,
  input wire [3:0] if_div_ratio_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  // deep inside a frame no commit can still be in flight
  sequence s_open;
    !serial_enable_n_in [*8];
  endsequence
  sequence s_up;
    rf_loop_powered_out && if_loop_powered_out;
  endsequence
  sequence s_down;
    !rf_loop_powered_out && !if_loop_powered_out;
  endsequence
  a_sel_holds: assert property (s_open |-> $stable(rf_loop_sel_out))
    else $error("loop select moved inside a frame");
  a_ratio_code: assert property ($stable(if_div_sel_out) [*2] |->
    if_div_ratio_out == (4'h1 << if_div_sel_out)) else $error("if divide ratio wrong");
  a_rf_tune_up: assert property ($rose(rf_loop_powered_out) |-> ##[0:2] rf_tune_busy_out)
    else $error("rf power-up without tune");
  a_if_tune_up: assert property ($rose(if_loop_powered_out) |-> ##[0:2] if_tune_busy_out)
    else $error("if power-up without tune");
  a_rf_tune_why: assert property ($rose(rf_tune_busy_out) |-> rf_loop_powered_out)
    else $error("rf tune on an unpowered loop");
  a_pin_up: assert property ($rose(power_down_n_pin_in) |-> ##[1:10] s_up)
    else $error("pin rise did not power up");
  a_pin_down: assert property ($fell(power_down_n_pin_in) |-> ##[1:10] s_down)
    else $error("pin fall did not power down");
  a_rf_abort: assert property ($fell(rf_loop_powered_out) |-> ##[0:1] !rf_tune_busy_out)
    else $error("tune survived power-down");
endmodule // scp_config_port_props
bind scp_config_port scp_config_port_props u_props (.sys_clk_in, .arst_n_in,
  .serial_enable_n_in, .power_down_n_pin_in, .rf_loop_sel_out, .rf_loop_powered_out,
  .if_loop_powered_out, .rf_tune_busy_out, .if_tune_busy_out, .if_div_sel_out,
  .if_div_ratio_out);
`default_nettype wire

// ==== tb/scp_host_model.sv ====
// host model: drives the three-wire serial bus
// assumes one task call at a time; serial clock period 32 ns
`timescale 1ns/1ps
`default_nettype none
module scp_host_model
(
  output var logic sclk_out,
  output var logic en_n_out,
  output var logic serial_data_line_out
);
  // clock parks low, enable high outside frames
  initial
  begin
    sclk_out = 1'b0;
    en_n_out = 1'b1;
    serial_data_line_out = 1'b0;
  end
  // data settles half a period before the rising edge
  task automatic bit_out(input logic b);
    serial_data_line_out = b;
    #16 sclk_out = 1'b1;
    #16 sclk_out = 1'b0;
  endtask
  // optional lead bits, then the word msb first
  task automatic send(input logic [21:0] word, input logic [3:0] lead, input logic xtra);
    #3.3 en_n_out = 1'b0;
    if (xtra)
      for (int i = 3; i >= 0; i--)
        bit_out(lead[i]);
    for (int i = 21; i >= 0; i--)
      bit_out(word[i]);
    serial_data_line_out = ~serial_data_line_out; // released line must not keep the last bit
    #16 en_n_out = 1'b1;
    #24;
  endtask
  // clocks with enable high, which must change nothing
  task automatic junk(input logic [7:0] bits);
    #3.3;
    for (int i = 7; i >= 0; i--)
      bit_out(bits[i]);
    serial_data_line_out = ~serial_data_line_out;
  endtask
endmodule // scp_host_model
`default_nettype wire

// ==== tb/tb.sv ====
// tb: self-checking bench for the serial configuration port
// assumes the host model drives the serial pins; apb driven here
`timescale 1ns/1ps
`default_nettype none
`include "scp_defines.vh"
module tb;
  logic        sys_clk_in, arst_n_in, serial_clk_in, serial_enable_n_in;
  logic        serial_data_line_in, power_down_n_pin_in, psel_in, penable_in, pwrite_in;
  logic        pready_out, pslverr_out, rf_loop_sel_out, rf_loop_powered_out;
  logic        if_loop_powered_out, rf_tune_busy_out, if_tune_busy_out;
  logic [1:0]  if_div_sel_out;
  logic [3:0]  if_div_ratio_out, sel_tab [4];
  logic [7:0]  paddr_in;
  logic [21:0] w;
  logic [31:0] pwdata_in, prdata_out;
  logic [32:0] exp_q [$];
  int          errors, checks_done, seed;
  scp_config_port u_scp_config_port (.sys_clk_in, .arst_n_in, .serial_clk_in,
    .serial_enable_n_in, .serial_data_line_in, .power_down_n_pin_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .rf_loop_sel_out, .rf_loop_powered_out, .if_loop_powered_out, .rf_tune_busy_out,
    .if_tune_busy_out, .if_div_sel_out, .if_div_ratio_out);
  scp_host_model u_scp_host_model (.sclk_out(serial_clk_in),
    .en_n_out(serial_enable_n_in), .serial_data_line_out(serial_data_line_in));
  initial
  begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // read results meet the oldest note
  always @(posedge sys_clk_in)
    if (psel_in && penable_in && pready_out === 1'b1 && !pwrite_in)
      chk("prdata", exp_q.pop_front(), {pslverr_out, prdata_out});
  // entered just after an edge; waits for pready, no fixed latency
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    if (!wr)
      exp_q.push_back(exp);
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    do @(posedge sys_clk_in); while (pready_out !== 1'b1);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  task automatic wr_word(input logic [21:0] word, input logic xtra);
    u_scp_host_model.send(word, 4'($random(seed)), xtra);
    repeat (12) @(posedge sys_clk_in);
  endtask
  task automatic summarize();
    if (exp_q.size() != 0)
      errors++;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watchdog: the tune wait dominates the run
  initial
  begin
    #200000;
    errors++;
    summarize();
  end
  initial
  begin
    seed = 14;
    sel_tab = '{`SCP_IDX_N_RF1, `SCP_IDX_R_RF2, `SCP_IDX_R_RF1, `SCP_IDX_N_RF2};
    {arst_n_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
    power_down_n_pin_in = 1'b1;
    repeat (5) @(posedge sys_clk_in);
    arst_n_in <= 1'b1;
    @(posedge sys_clk_in);
    chk("div_ratio", 33'h1, 33'(if_div_ratio_out));
    apb(1'b0, `SCP_APB_CTRL, 32'h0, 33'(`SCP_CTRL_RST));
    apb(1'b0, 8'h10, 32'h0, 33'h100000000);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      w = {`SCP_IDX_AUX, 18'($random(seed))};
      w[`SCP_IFDIV_MSB:`SCP_IFDIV_LSB] = 2'(i);
      wr_word(w, 1'b0);
      chk("div_ratio", 33'(4'h1 << i), 33'(if_div_ratio_out));
      chk("div_sel", 33'(i), 33'(if_div_sel_out));
      apb(1'b1, `SCP_APB_CTRL, 32'(`SCP_IDX_AUX), 32'h0);
      apb(1'b0, `SCP_APB_REGRD, 32'h0, 33'(w[17:0]));
    end
    $display("test divider done");
    w = {`SCP_IDX_GAIN, 18'($random(seed))};
    wr_word(w, 1'b1);
    apb(1'b0, `SCP_APB_LASTWORD, 32'h0, 33'(w));
    u_scp_host_model.junk(8'($random(seed)));
    repeat (12) @(posedge sys_clk_in);
    apb(1'b0, `SCP_APB_LASTWORD, 32'h0, 33'(w));
    apb(1'b0, `SCP_APB_STATUS, 32'h0, 33'h000000001);
    foreach (sel_tab[k])
    begin
      wr_word({sel_tab[k], 18'($random(seed))}, 1'b0);
      chk("loop_sel", 33'(k % 2), 33'(rf_loop_sel_out));
    end
    $display("test framing done");
    wr_word({`SCP_IDX_PWR, 18'h3}, 1'b0);
    chk("powered", 33'h3, 33'({rf_loop_powered_out, if_loop_powered_out}));
    power_down_n_pin_in <= 1'b0;
    repeat (12) @(posedge sys_clk_in);
    chk("powered", 33'h0, 33'({rf_loop_powered_out, if_loop_powered_out}));
    chk("tuning", 33'h0, 33'({rf_tune_busy_out, if_tune_busy_out}));
    power_down_n_pin_in <= 1'b1;
    repeat (12) @(posedge sys_clk_in);
    chk("powered", 33'h3, 33'({rf_loop_powered_out, if_loop_powered_out}));
    chk("tuning", 33'h3, 33'({rf_tune_busy_out, if_tune_busy_out}));
    wr_word({`SCP_IDX_PWR, 18'h0}, 1'b0);
    chk("powered", 33'h0, 33'({rf_loop_powered_out, if_loop_powered_out}));
    chk("tuning", 33'h0, 33'({rf_tune_busy_out, if_tune_busy_out}));
    wr_word({`SCP_IDX_PWR, 18'h3}, 1'b0);
    chk("powered", 33'h3, 33'({rf_loop_powered_out, if_loop_powered_out}));
    repeat (`SCP_TUNE_NS / `SCP_CLK_NS - 100) @(posedge sys_clk_in);
    chk("tuning", 33'h3, 33'({rf_tune_busy_out, if_tune_busy_out}));
    repeat (150) @(posedge sys_clk_in);
    chk("tuning", 33'h0, 33'({rf_tune_busy_out, if_tune_busy_out}));
    wr_word({`SCP_IDX_N_IF, 18'h15A5}, 1'b0);
    chk("tuning", 33'h1, 33'({rf_tune_busy_out, if_tune_busy_out}));
    $display("test power done");
    summarize();
  end
endmodule // tb
`default_nettype wire
